// >>> pif_pkg.sv
// package: register map, field positions and reset values of the peripheral flag block
package pif_pkg;

  localparam logic [3:0] PIF_OFS_FLAGS_ONE = 4'h0;
  localparam logic [3:0] PIF_OFS_FLAGS_TWO = 4'h1;
  localparam logic [3:0] PIF_OFS_IRQ_STAT  = 4'h2;
  localparam logic [3:0] PIF_OFS_IRQ_MASK  = 4'h3;

  localparam int PIF_POS_PARALLEL  = 7;
  localparam int PIF_POS_CONVERTER = 6;
  localparam int PIF_POS_RX        = 5;
  localparam int PIF_POS_TX        = 4;
  localparam int PIF_POS_SYNC      = 3;
  localparam int PIF_POS_CAPCOMP   = 2;
  localparam int PIF_POS_PERIOD    = 1;
  localparam int PIF_POS_OVERFLOW  = 0;

  localparam int PIF_POS_OSC_FAIL  = 7;
  localparam int PIF_POS_CMP_CHG   = 6;
  localparam int PIF_POS_NV_DONE   = 4;

  localparam logic [7:0] PIF_ONE_WR_MASK = 8'hcf;
  localparam logic [7:0] PIF_TWO_WR_MASK = 8'hd0;
  localparam logic [7:0] PIF_ONE_RESET   = 8'h00;
  localparam logic [7:0] PIF_TWO_RESET   = 8'h00;
  localparam logic [7:0] PIF_MASK_RESET  = 8'h00;
  localparam logic [7:0] PIF_STAT_RESET  = 8'h00;

  typedef enum logic [1:0] {
    PIF_CCP_CAPTURE,
    PIF_CCP_COMPARE,
    PIF_CCP_PWM,
    PIF_CCP_OFF
  } pif_ccp_mode_e;

  typedef struct packed {
    logic parallel_access;
    logic converter_done;
    logic sync_serial_done;
    logic timer_captured;
    logic timer_compare_match;
    logic period_match;
    logic timer_overflow;
    logic osc_failure;
    logic comparator_change;
    logic nv_write_done;
  } pif_events_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pif_bus_s;

  typedef struct packed {
    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic       rx_full;
    logic       tx_empty;
  } pif_state_s;

endpackage

// >>> pif_flags.sv
// peripheral interrupt flag registers with polling, sticky flags and an interrupt output raised by first-register flags only
// What this block does
// [R01] parallel access sets bit 7, sticky
// [R02] small package: parallel flag reads zero
// [R03] conversion done sets sticky converter flag
// [R04] rx flag follows rx buffer full
// [R05] tx flag follows tx buffer empty
// [R06] sync serial completion sets sticky flag
// [R07] capture mode: timer capture sets flag
// [R08] compare mode: timer match sets flag
// [R09] eight bit timer period match sets flag
// [R10] sixteen bit overflow sets bit 0
// [R11] flags set regardless of any enable
// [R12] second register: oscillator, comparator, nv flags
// [R13] software writes store; hardware set wins
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module pif_flags
  import pif_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  input  wire logic [3:0]    addr_in,
  input  wire logic [7:0]    wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output logic      [7:0]    rdata_out,
  input  wire pif_events_s   events_in,
  input  wire pif_ccp_mode_e ccp_mode_in,
  input  wire logic          rx_data_arrive_in,
  input  wire logic          rx_buffer_read_in,
  input  wire logic          tx_buffer_drained_in,
  input  wire logic          tx_buffer_write_in,
  output logic      [7:0]    flags_one_out,
  output logic      [7:0]    flags_two_out,
  output logic               irq_out
);

  pif_state_s  st_reg;
  pif_state_s  st_next;
  pif_bus_s    bus;
  logic [7:0]  set_one;
  logic [7:0]  set_two;
  logic [7:0]  view_one;
  logic [7:0]  view_two;
  logic [7:0]  rise;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  always_comb begin
    set_one = 8'h00;
    set_two = 8'h00;
    // [R11] no enable gating on sets
    // [R01] parallel port access
    set_one[PIF_POS_PARALLEL]  = events_in.parallel_access & ~SMALL_PACKAGE;
    // [R03] conversion finished
    set_one[PIF_POS_CONVERTER] = events_in.converter_done;
    // [R06] sync port transfer done
    set_one[PIF_POS_SYNC]      = events_in.sync_serial_done;
    // [R07] capture in capture mode; pwm mode sets nothing
    // [R08] match in compare mode
    set_one[PIF_POS_CAPCOMP]   = (ccp_mode_in == PIF_CCP_CAPTURE && events_in.timer_captured) ||
                                 (ccp_mode_in == PIF_CCP_COMPARE && events_in.timer_compare_match);
    // [R09] period match
    set_one[PIF_POS_PERIOD]    = events_in.period_match;
    // [R10] overflow
    set_one[PIF_POS_OVERFLOW]  = events_in.timer_overflow;
    // [R12] second register sources
    set_two[PIF_POS_OSC_FAIL]  = events_in.osc_failure;
    set_two[PIF_POS_CMP_CHG]   = events_in.comparator_change;
    set_two[PIF_POS_NV_DONE]   = events_in.nv_write_done;
  end

  // read-only status bits come from the buffer trackers, not storage
  always_comb begin
    view_one = st_reg.flags_one & PIF_ONE_WR_MASK;
    // [R04] rx flag mirrors buffer
    view_one[PIF_POS_RX] = st_reg.rx_full;
    // [R05] tx flag mirrors buffer
    view_one[PIF_POS_TX] = st_reg.tx_empty;
    // [R02] absent pin, reads zero
    if (SMALL_PACKAGE) begin
      view_one[PIF_POS_PARALLEL] = 1'b0;
    end
    view_two = st_reg.flags_two & PIF_TWO_WR_MASK;
  end

  always_comb begin
    st_next = st_reg;
    // [R04] read of rx buffer clears; new data wins
    if (rx_data_arrive_in) begin
      st_next.rx_full = 1'b1;
    end else if (rx_buffer_read_in) begin
      st_next.rx_full = 1'b0;
    end
    // [R05] write of tx buffer fills; drain wins
    if (tx_buffer_drained_in) begin
      st_next.tx_empty = 1'b1;
    end else if (tx_buffer_write_in) begin
      st_next.tx_empty = 1'b0;
    end
    // [R13] software stores writable bits
    if (bus.wr && bus.addr == PIF_OFS_FLAGS_ONE) begin
      st_next.flags_one = bus.wdata & PIF_ONE_WR_MASK;
    end
    if (bus.wr && bus.addr == PIF_OFS_FLAGS_TWO) begin
      st_next.flags_two = bus.wdata & PIF_TWO_WR_MASK;
    end
    // [R13] hardware set overrides same-cycle clear
    st_next.flags_one = st_next.flags_one | set_one;
    st_next.flags_two = st_next.flags_two | set_two;
    if (SMALL_PACKAGE) begin
      st_next.flags_one[PIF_POS_PARALLEL] = 1'b0;
    end
    if (bus.wr && bus.addr == PIF_OFS_IRQ_MASK) begin
      st_next.irq_mask = bus.wdata;
    end
    // write one to clear; a new rise the same cycle stays set
    if (bus.wr && bus.addr == PIF_OFS_IRQ_STAT) begin
      st_next.irq_stat = st_reg.irq_stat & ~bus.wdata;
    end
    st_next.irq_stat = st_next.irq_stat | rise;
    st_next.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        PIF_OFS_FLAGS_ONE: st_next.rdata = view_one;
        PIF_OFS_FLAGS_TWO: st_next.rdata = view_two;
        PIF_OFS_IRQ_STAT:  st_next.rdata = st_reg.irq_stat;
        PIF_OFS_IRQ_MASK:  st_next.rdata = st_reg.irq_mask;
        default:           st_next.rdata = 8'h00;
      endcase
    end
  end

  // status tracks rising flag-one bits, so level bits (rx, tx) raise it once
  logic [7:0] view_one_prev;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      view_one_prev <= 8'h00;
    end else begin
      view_one_prev <= view_one;
    end
  end
  assign rise = view_one & ~view_one_prev;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg           <= '0;
      st_reg.flags_one <= PIF_ONE_RESET;
      st_reg.flags_two <= PIF_TWO_RESET;
      st_reg.irq_stat  <= PIF_STAT_RESET;
      st_reg.irq_mask  <= PIF_MASK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_out     = st_reg.rdata;
  assign flags_one_out = view_one;
  assign flags_two_out = view_two;
  assign irq_out       = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule

// >>> pif_periph.sv
// peripheral model: one event pulse per fired bit
`timescale 1ns/1ps
module pif_periph
  import pif_pkg::*;
(
  input  wire logic [9:0] fire_in,
  output pif_events_s     events_out
);
  assign events_out = fire_in;
endmodule

// >>> pif_flags_chk.sv
// checker: flag setting at the block ports
`timescale 1ns/1ps
module pif_flags_chk
  import pif_pkg::*;
(
  input wire logic          clk_in,
  input wire logic          rstn_in,
  input wire pif_events_s   events_in,
  input wire pif_ccp_mode_e ccp_mode_in,
  input wire logic          rx_data_arrive_in,
  input wire logic          tx_buffer_drained_in,
  input wire logic [7:0]    flags_one_out,
  input wire logic [7:0]    flags_two_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  conv_set_a: assert property (events_in.converter_done |=> flags_one_out[6]) else $error("converter");
  rx_full_a: assert property (rx_data_arrive_in |=> flags_one_out[5]) else $error("rx flag");
  tx_empty_a: assert property (tx_buffer_drained_in |=> flags_one_out[4]) else $error("tx flag");
  sync_set_a: assert property (events_in.sync_serial_done |=> flags_one_out[3]) else $error("sync");
  cap_set_a: assert property (events_in.timer_captured && ccp_mode_in == PIF_CCP_CAPTURE |=> flags_one_out[2])
    else $error("capture");
  per_set_a: assert property (events_in.period_match |=> flags_one_out[1]) else $error("period");
  ovf_set_a: assert property (events_in.timer_overflow |=> flags_one_out[0]) else $error("overflow");
  osc_set_a: assert property (events_in.osc_failure |=> flags_two_out[7]) else $error("osc");
  cmp_set_a: assert property (events_in.timer_compare_match && ccp_mode_in == PIF_CCP_COMPARE |=> flags_one_out[2])
    else $error("compare");
  chg_set_a: assert property (events_in.comparator_change |=> flags_two_out[6]) else $error("comparator");
  nv_set_a: assert property (events_in.nv_write_done |=> flags_two_out[4]) else $error("nv write");
endmodule
bind pif_flags pif_flags_chk u_pif_flags_chk (.*);

// >>> pif_flags_tb.sv
// testbench: flag block against an integer model
`timescale 1ns/1ps
module pif_flags_tb;
  import pif_pkg::*;
  logic          clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq_out;
  logic [3:0]    addr_in = 4'h0, ser = 4'h0;
  logic [7:0]    wdata_in = 8'h00, rdata_out, flags_one_out, flags_two_out, small_one;
  logic [9:0]    fire = 10'h000;
  pif_ccp_mode_e ccp_mode_in = PIF_CCP_OFF;
  pif_events_s   events_in;
  int            num_errors, samples_checked, cyc, m[16];
  int            seed = 75427;
  // above 7: second register bit
  int            map[10] = '{12, 14, 15, 0, 1, 2, 2, 3, 6, 7};
  always #20 clk_in = ~clk_in;
  pif_periph u_pif_periph (.fire_in(fire), .events_out(events_in));
  pif_flags u_pif_flags (.rx_data_arrive_in(ser[3]), .rx_buffer_read_in(ser[2]), .tx_buffer_drained_in(ser[1]),
    .tx_buffer_write_in(ser[0]), .*);
  // small package variant, same stimulus, only flag view compared
  pif_flags #(.SMALL_PACKAGE(1'b1)) u_pif_flags_small (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(), .events_in(events_in),
    .ccp_mode_in(ccp_mode_in), .rx_data_arrive_in(ser[3]), .rx_buffer_read_in(ser[2]),
    .tx_buffer_drained_in(ser[1]), .tx_buffer_write_in(ser[0]), .flags_one_out(small_one),
    .flags_two_out(), .irq_out());
  task automatic cmp(logic [7:0] got, int exp);
    samples_checked++;
    if (got !== exp[7:0]) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp[7:0]);
    end
  endtask
  task automatic print_verdict;
    $display("%0d compares, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (++cyc == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  // one write, events and serial pulses in the same cycle
  task automatic op(int a, int d, int w, int f, int s);
    int s0 = 0, s1 = 0, old = m[0];
    int c0 = (s[2] << 5) | (s[0] << 4);
    pif_ccp_mode_e md = pif_ccp_mode_e'(2'($random(seed)));
    for (int i = 0; i < 10; i++)
      if (f[i] && (i != 5 || md == PIF_CCP_COMPARE) && (i != 6 || md == PIF_CCP_CAPTURE))
        if (map[i] > 7) s1 |= 1 << (map[i] - 8);
        else s0 |= 1 << map[i];
    s0 |= (s[3] << 5) | (s[1] << 4);
    if (w && a == 0) m[0] = (d & PIF_ONE_WR_MASK) | (m[0] & 8'h30);
    if (w && a == 1) m[1] = d & PIF_TWO_WR_MASK;
    if (w && a == 2) m[2] &= ~d;
    if (w && a == 3) m[3] = d & 8'hff;
    // hardware set wins over same-cycle clear
    m[0] = (m[0] & ~c0) | s0;
    m[1] |= s1;
    m[2] |= m[0] & ~old;
    @(posedge clk_in);
    addr_in <= a[3:0];
    wdata_in <= d[7:0];
    wr_in <= w[0];
    fire <= f[9:0];
    ser <= s[3:0];
    ccp_mode_in <= md;
    @(posedge clk_in);
    wr_in <= 1'b0;
    fire <= 10'h000;
    ser <= 4'h0;
  endtask
  task automatic rd(int a);
    @(posedge clk_in);
    addr_in <= a[3:0];
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    cmp(rdata_out, m[a]);
    cmp(flags_one_out, m[0]);
    cmp(flags_two_out, m[1]);
    cmp(small_one, m[0] & 8'h7f);
    cmp(8'(irq_out), (m[2] & m[3]) != 0);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 16; a++) rd(a);
    $display("reset values done");
    for (int r = 0; r < 60; r++) begin
      op($random(seed) & 3, $random(seed), r % 3 == 0, r < 20 ? 1 << (r % 10) : $random(seed), 0);
      rd(r % 4);
    end
    $display("event flags done");
    for (int k = 0; k < 16; k++) begin
      op(0, 0, 0, 0, k);
      rd(k % 2);
    end
    $display("serial flags done");
    print_verdict();
  end
endmodule
